// file: design/uotr_defines.vh
`ifndef UOTR_DEFINES_VH
`define UOTR_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define UOTR_ADDR_W 8
`define UOTR_OFS_OTG_IE 8'h00
`define UOTR_OFS_FRM_HIGH 8'h04
`define UOTR_OFS_TOKEN 8'h08
`define UOTR_OFS_OTG_STAT 8'h0C

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define UOTR_IE_MASK 8'hFD
`define UOTR_IE_W 8
`define UOTR_BIT_ID 7
`define UOTR_BIT_T1MS 6
`define UOTR_BIT_LSTATE 5
`define UOTR_BIT_ACTV 4
`define UOTR_BIT_SESSV 3
`define UOTR_BIT_SESEND 2
`define UOTR_BIT_VBUSV 0
`define UOTR_FRMH_W 3
`define UOTR_TOK_W 8
`define UOTR_TOK_TYPE_HI 7
`define UOTR_TOK_TYPE_LO 4
`define UOTR_TOK_EP_HI 3
`define UOTR_TOK_EP_LO 0
`define UOTR_IE_HI 7
`define UOTR_IE_LO 0
`define UOTR_BIT_RSVD 1
`define UOTR_BYTE_LANE 0
`define UOTR_TYPE_W 4
`define UOTR_EP_W 4
`define UOTR_DATA_W 32

// ----------------------------------------------------------------------
// Token type codes and reset values
// ----------------------------------------------------------------------
`define UOTR_TYPE_OUT 4'h1
`define UOTR_TYPE_IN 4'h9
`define UOTR_TYPE_SETUP 4'hD
`define UOTR_RST_IE 8'h00
`define UOTR_RST_FRMH 3'h0
`define UOTR_RST_TOK 8'h00
`define UOTR_RST_TYPE 4'h0
`define UOTR_RST_EP 4'h0
`define UOTR_ZERO32 32'h00000000

`endif

// file: design/uotr_event_status.v
// ----------------------------------------------------------------------
// Sticky event status with read-to-clear and mask gating
// ----------------------------------------------------------------------
module uotr_event_status #(
  parameter W = 8
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] event_pulse,
  input wire [W-1:0] impl_mask,
  input wire [W-1:0] enable,
  input wire read_clear,
  output reg [W-1:0] status,
  output wire irq
);

  // Set beats clear so an event landing on the clearing read is kept
  always @(posedge clk) begin
    if (srst) begin
      status <= {W{1'b0}};
    end else begin
      status <= ((read_clear ? {W{1'b0}} : status) | event_pulse) & impl_mask;
    end
  end

  // Level request while any enabled flag is pending
  assign irq = |(status & enable);

endmodule // uotr_event_status

// file: design/uotr_regs.v
// The APB register port and the address map were decided locally.
`include "uotr_defines.vh"

module uotr_regs #(
  parameter ADDR_W = `UOTR_ADDR_W
) (
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sof_received,
  input wire [2:0] sof_frame_upper,
  input wire identity_pin_event,
  input wire millisecond_timer_event,
  input wire line_state_event,
  input wire bus_activity_event,
  input wire session_valid_event,
  input wire b_session_end_event,
  input wire a_vbus_valid_event,
  output reg token_issue,
  output reg [3:0] token_type_field,
  output reg [3:0] token_endpoint_field,
  output wire otg_irq
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Zero wait state slave: the access phase always completes at once
  wire setup_phase;
  wire access;
  wire wr;
  wire rd;
  wire hit_ie;
  wire hit_frm;
  wire hit_tok;
  wire hit_stat;
  wire mapped;
  wire ro_hit;

  // One-hot bus phase codes
  localparam [2:0] PH_IDLE = 3'h1;
  localparam [2:0] PH_SETUP = 3'h2;
  localparam [2:0] PH_ACCESS = 3'h4;

  reg [2:0] phase;
  reg [2:0] next_phase;

  // An access counts only after a setup cycle, so a stray enable is ignored
  always @* begin
    case (phase)
      PH_IDLE: begin
        next_phase = (psel && !penable) ? PH_SETUP : PH_IDLE;
      end
      PH_SETUP: begin
        if (psel && penable) begin
          next_phase = PH_ACCESS;
        end else if (psel) begin
          next_phase = PH_SETUP;
        end else begin
          next_phase = PH_IDLE;
        end
      end
      PH_ACCESS: begin
        next_phase = (psel && !penable) ? PH_SETUP : PH_IDLE;
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  // Phase register; reset leaves the bus idle
  always @(posedge clk) begin
    if (srst) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Phase qualifiers; only byte lane 0 carries register bits
  assign setup_phase = psel & ~penable;
  assign access = psel & penable & (phase == PH_SETUP);
  assign wr = access & pwrite & pstrb[`UOTR_BYTE_LANE];
  assign rd = access & ~pwrite;

  // Full address compare, so no alias of a word reaches it
  assign hit_ie = addr_hit(paddr, `UOTR_OFS_OTG_IE);
  assign hit_frm = addr_hit(paddr, `UOTR_OFS_FRM_HIGH);
  assign hit_tok = addr_hit(paddr, `UOTR_OFS_TOKEN);
  assign hit_stat = addr_hit(paddr, `UOTR_OFS_OTG_STAT);
  assign mapped = hit_ie | hit_frm | hit_tok | hit_stat;
  assign ro_hit = hit_frm | hit_stat;

  // No wait states: the slave is always ready in the access phase
  assign pready = 1'b1;
  // Unmapped addresses, and writes to read-only words, answer with an error
  assign pslverr = access & (~mapped | (pwrite & ro_hit));

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Match one word address
  function addr_hit(
    input [ADDR_W-1:0] a,
    input [ADDR_W-1:0] ofs
  );
    addr_hit = (a == ofs);
  endfunction

  // Only the three defined codes launch a transaction
  function type_defined(
    input [`UOTR_TYPE_W-1:0] t
  );
    type_defined = (t == `UOTR_TYPE_OUT) | (t == `UOTR_TYPE_IN) | (t == `UOTR_TYPE_SETUP);
  endfunction

  // Zero-extend an eight-bit register to a bus word
  function [`UOTR_DATA_W-1:0] word_from_byte(
    input [`UOTR_IE_W-1:0] v
  );
    word_from_byte = {{(`UOTR_DATA_W - `UOTR_IE_W){1'b0}}, v};
  endfunction

  // Zero-extend the frame bits; the upper bits read zero
  function [`UOTR_DATA_W-1:0] word_from_frame(
    input [`UOTR_FRMH_W-1:0] v
  );
    word_from_frame = {{(`UOTR_DATA_W - `UOTR_FRMH_W){1'b0}}, v};
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Architectural state
  reg [`UOTR_IE_W-1:0] otg_interrupt_enable;
  reg [`UOTR_FRMH_W-1:0] frame_number_upper_bits;
  reg [`UOTR_TOK_W-1:0] host_token_command;

  // Next values, worked out combinationally
  reg [`UOTR_IE_W-1:0] next_ie;
  reg [`UOTR_FRMH_W-1:0] next_frmh;
  reg [`UOTR_TOK_W-1:0] next_tok;
  reg next_issue;
  reg [`UOTR_TYPE_W-1:0] next_type_field;
  reg [`UOTR_EP_W-1:0] next_ep_field;
  reg [`UOTR_DATA_W-1:0] next_prdata;

  // Status and event wiring
  wire [`UOTR_IE_W-1:0] otg_status;
  wire [`UOTR_IE_W-1:0] event_vec;
  wire [`UOTR_TYPE_W-1:0] wr_type;
  wire [`UOTR_EP_W-1:0] wr_ep;
  wire tok_wr;

  // Fields of the word being written
  assign wr_type = pwdata[`UOTR_TOK_TYPE_HI:`UOTR_TOK_TYPE_LO];
  assign wr_ep = pwdata[`UOTR_TOK_EP_HI:`UOTR_TOK_EP_LO];
  assign tok_wr = wr & hit_tok;

  // ----------------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------------
  // Only the documented enable bits take a write; bit 1 is never stored
  always @* begin
    next_ie = otg_interrupt_enable;
    if (wr && hit_ie) begin
      next_ie = pwdata[`UOTR_IE_HI:`UOTR_IE_LO] & `UOTR_IE_MASK;
    end
  end

  // Enable bits clear on reset, so every source starts masked
  always @(posedge clk) begin
    if (srst) begin
      otg_interrupt_enable <= `UOTR_RST_IE;
    end else begin
      otg_interrupt_enable <= next_ie;
    end
  end

  // ----------------------------------------------------------------------
  // Frame number upper bits
  // ----------------------------------------------------------------------
  // A received start of frame reloads the upper frame bits
  always @* begin
    next_frmh = frame_number_upper_bits;
    if (sof_received) begin
      next_frmh = sof_frame_upper;
    end
  end

  // Read-only to software: no bus path reaches this register
  always @(posedge clk) begin
    if (srst) begin
      frame_number_upper_bits <= `UOTR_RST_FRMH;
    end else begin
      frame_number_upper_bits <= next_frmh;
    end
  end

  // ----------------------------------------------------------------------
  // Token register and issue strobe
  // ----------------------------------------------------------------------
  // Eight stored bits; reserved codes are kept so software can read them back
  always @* begin
    next_tok = host_token_command;
    if (tok_wr) begin
      next_tok = pwdata[`UOTR_TOK_W-1:0];
    end
  end

  // Token word register
  always @(posedge clk) begin
    if (srst) begin
      host_token_command <= `UOTR_RST_TOK;
    end else begin
      host_token_command <= next_tok;
    end
  end

  // Strobe and fields for the engine; a reserved code never launches
  always @* begin
    next_issue = tok_wr & type_defined(wr_type);
    next_type_field = token_type_field;
    next_ep_field = token_endpoint_field;
    if (tok_wr) begin
      next_type_field = wr_type;
      next_ep_field = wr_ep;
    end
  end

  // Issue is a single-cycle strobe; the fields hold the last write
  always @(posedge clk) begin
    if (srst) begin
      token_issue <= 1'b0;
      token_type_field <= `UOTR_RST_TYPE;
      token_endpoint_field <= `UOTR_RST_EP;
    end else begin
      token_issue <= next_issue;
      token_type_field <= next_type_field;
      token_endpoint_field <= next_ep_field;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and masking
  // ----------------------------------------------------------------------
  // Events laid out on the same bit positions as the enable register
  assign event_vec[`UOTR_BIT_ID] = identity_pin_event;
  assign event_vec[`UOTR_BIT_T1MS] = millisecond_timer_event;
  assign event_vec[`UOTR_BIT_LSTATE] = line_state_event;
  assign event_vec[`UOTR_BIT_ACTV] = bus_activity_event;
  assign event_vec[`UOTR_BIT_SESSV] = session_valid_event;
  assign event_vec[`UOTR_BIT_SESEND] = b_session_end_event;
  assign event_vec[`UOTR_BIT_RSVD] = 1'b0;
  assign event_vec[`UOTR_BIT_VBUSV] = a_vbus_valid_event;

  // Each bit reaches the output only through its own enable bit
  uotr_event_status #(
    .W(`UOTR_IE_W)
  ) u_status (
    .clk(clk),
    .srst(srst),
    .event_pulse(event_vec),
    .impl_mask(`UOTR_IE_MASK),
    .enable(otg_interrupt_enable),
    .read_clear(rd & hit_stat),
    .status(otg_status),
    .irq(otg_irq)
  );

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Captured in the setup cycle so data stand through the access phase
  always @* begin
    next_prdata = prdata;
    if (setup_phase && !pwrite) begin
      next_prdata = `UOTR_ZERO32;
      if (hit_ie) begin
        next_prdata = word_from_byte(otg_interrupt_enable);
      end
      if (hit_frm) begin
        next_prdata = word_from_frame(frame_number_upper_bits);
      end
      if (hit_tok) begin
        next_prdata = word_from_byte(host_token_command);
      end
      if (hit_stat) begin
        next_prdata = word_from_byte(otg_status);
      end
    end
  end

  // Cleared on reset; an unmapped word reads zero because the setup capture defaults to zero
  always @(posedge clk) begin
    if (srst) begin
      prdata <= `UOTR_ZERO32;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------------
  // Integration notes
  // ----------------------------------------------------------------------
  // The second USB module is a second copy of this block at system level
  // Status is captured at setup but cleared at access: a flag set at the setup edge
  // is cleared at access without being read, so it is lost
  // Status flags set whatever the enables say; enables gate only the line
  // Only byte lane 0 carries register bits, so a write without it is dropped
  // A reserved token code is stored and readable but starts no transaction
  // The frame bits come from the receive side; the bus cannot write them
  // The phase tracker ignores an enable that arrives without a setup cycle

endmodule // uotr_regs

// file: verif/uotr_chk.sv
module uotr_chk #(
  parameter ADDR_W = 8
) (
  input logic clk,
  input logic srst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic token_issue,
  input logic [3:0] token_type_field,
  input logic otg_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Access qualifiers; only a status read or enable write may drop the line
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  wire [3:0] wty = pwdata[7:4];
  wire ok = wty == 4'h1 || wty == 4'h9 || wty == 4'hD;
  wire clr = (rd && paddr == 8'h0C) || (wr && paddr == 8'h00);
  sequence tok_wr;
    wr && paddr == 8'h08 && pstrb[0];
  endsequence
  ie_read_a: assert property (rd && paddr == 8'h00 |-> prdata[31:8] == 0 && !prdata[1])
    else $error("ie read");
  frm_read_a: assert property (rd && paddr == 8'h04 |-> prdata[31:3] == 0)
    else $error("frame read");
  tok_read_a: assert property (rd && paddr == 8'h08 |-> prdata[31:8] == 0)
    else $error("token read");
  tok_issue_a: assert property (tok_wr ##0 ok |=> token_issue)
    else $error("no issue");
  tok_rsvd_a: assert property (tok_wr ##0 !ok |=> !token_issue)
    else $error("reserved issue");
  tok_type_a: assert property (tok_wr |=> token_type_field == $past(wty))
    else $error("token type");
  tok_pulse_a: assert property (token_issue |=> !token_issue)
    else $error("long issue");
  irq_drop_a: assert property ($fell(otg_irq) |-> $past(srst) || $past(clr))
    else $error("irq drop");
endmodule // uotr_chk

// file: verif/uotr_usb_peer.sv
module uotr_usb_peer (
  input logic clk,
  output logic [7:0] ev = 8'h00,
  output logic sof = 1'h0,
  output logic [2:0] frm = 3'h5
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle pulses; frame bits invert afterwards so stale values never pass
  task fire(input logic [7:0] e, input logic s, input logic [2:0] f);
    ev <= e;
    sof <= s;
    frm <= f;
    @(posedge clk);
    ev <= 8'h00;
    sof <= 1'h0;
    frm <= ~f;
  endtask
endmodule // uotr_usb_peer

// file: verif/uotr_regs_tb_top.sv
module uotr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, ev;
  logic [31:0] pwdata = 32'h0, prdata, r, e, q[$];
  logic [3:0] pstrb = 4'hF, ty, ty_f, ep_f;
  logic pready, pslverr, tok, irq, sof;
  logic [2:0] frm;
  int failures = 0, samples_checked = 0, seed = 75, issued = 0, i;
  // 50 MHz clock
  initial forever #10 clk = ~clk;
  uotr_regs dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sof_received(sof), .sof_frame_upper(frm), .identity_pin_event(ev[7]),
    .millisecond_timer_event(ev[6]), .line_state_event(ev[5]), .bus_activity_event(ev[4]),
    .session_valid_event(ev[3]), .b_session_end_event(ev[2]), .a_vbus_valid_event(ev[0]),
    .token_issue(tok), .token_type_field(ty_f), .token_endpoint_field(ep_f), .otg_irq(irq));
  uotr_usb_peer peer (.clk(clk), .ev(ev), .sof(sof), .frm(frm));
  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // One transfer, held until pready is seen high at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    xfer(1'h0, a, 32'h0);
  endtask
  // Read data taken at the access edge, oldest note first
  always @(posedge clk)
    if (psel && penable && !pwrite) chk(prdata, q.pop_front());
  always @(posedge clk) if (tok === 1'h1) issued++;
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    r = $random(seed);
    xfer(1'h1, 8'h00, r);
    rd(8'h00, r & 32'hFD);
    // Each source raises the line when enabled, stays silent when masked
    for (i = 0; i < 8; i++) if (i != 1) begin
      xfer(1'h1, 8'h00, 32'h1 << i);
      peer.fire(8'h1 << i, 1'h0, 3'h0);
      @(negedge clk) chk(irq, 1'h1);
      rd(8'h0C, 32'h1 << i);
      @(negedge clk) chk(irq, 1'h0);
      xfer(1'h1, 8'h00, 32'hFD ^ (32'h1 << i));
      peer.fire(8'h1 << i, 1'h0, 3'h0);
      @(negedge clk) chk(irq, 1'h0);
      rd(8'h0C, 32'h1 << i);
    end
    repeat (4) begin
      r = $random(seed);
      peer.fire(8'h00, 1'h1, r[2:0]);
      rd(8'h04, {29'h0, r[2:0]});
    end
    // Three defined codes, then a reserved one that must not launch
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      ty = i == 0 ? 4'h1 : i == 1 ? 4'h9 : i == 2 ? 4'hD : 4'h3;
      e = {24'h0, ty, r[3:0]};
      xfer(1'h1, 8'h08, {r[31:8], e[7:0]});
      @(negedge clk) chk({ty_f, ep_f}, e[7:0]);
      rd(8'h08, e);
    end
    chk(issued, 3);
    pstrb <= 4'h0;
    xfer(1'h1, 8'h08, 32'h1F);
    pstrb <= 4'hF;
    rd(8'h08, e);
    print_verdict;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict;
  end
  task print_verdict;
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // uotr_regs_tb_top
bind uotr_regs uotr_chk #(.ADDR_W(ADDR_W)) chk_i (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .token_issue(token_issue), .token_type_field(token_type_field),
  .otg_irq(otg_irq));
